// File: logic/pct_pkg.sv
// shared constants and carrier types of the power control timer
package pct_pkg;

	// ==========================================================
	// sizes
	localparam int CNT_W_DEF = 24;
	localparam int CC_NUM_DEF = 6;
	localparam int PAIR_NUM = 4;
	localparam int PIN_NUM = 8;
	localparam int WR_W = 24;
	localparam int SYNC_STAGES = 2;
	localparam int FILT_W = 4;
	localparam int DT_W = 8;

	// ==========================================================
	// output matrix modes
	localparam logic [1:0] OUTPUT_MATRIX_STRAIGHT = 2'h0;
	localparam logic [1:0] OUTPUT_MATRIX_PAIRS = 2'h1;
	localparam logic [1:0] OUTPUT_MATRIX_CH0 = 2'h2;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		PCT_W_PERIOD_BUFFER,
		PCT_W_CCB,
		PCT_W_PATTERN_BUFFER,
		PCT_W_COUNT,
		PCT_W_CTRL,
		PCT_W_FAULT
	} pct_wsel_t;

	typedef enum logic [1:0] {
		PCT_RF_NONE,
		PCT_RF_RESTART,
		PCT_RF_HALT,
		PCT_RF_BLANK
	} pct_rfact_t;

	typedef struct packed {
		logic dir;
		logic top_cc0;
		logic count_events;
		logic cap_en;
		logic [1:0] output_matrix;
		logic [PAIR_NUM-1:0] swap;
		logic [DT_W-1:0] dead_time;
	} pct_ctrl_t;

	typedef struct packed {
		pct_rfact_t action;
		logic [FILT_W-1:0] filt;
		logic [FILT_W-1:0] blank;
		logic qual;
		logic rf_en;
		logic nrf_en;
		logic nrf_filt;
		logic [PIN_NUM-1:0] safe_level;
	} pct_fault_t;

	typedef struct packed {
		logic [PIN_NUM-1:0] en;
		logic [PIN_NUM-1:0] val;
	} pct_pattern_value_t;

	typedef struct packed {
		logic en;
		pct_wsel_t sel;
		logic [2:0] idx;
		logic [WR_W-1:0] data;
		logic debugger;
	} pct_wr_t;

endpackage : pct_pkg

// File: logic/pct_dead_time.sv
// dead-time splitter for one low-side/high-side pair
`timescale 1ns/1ps
`default_nettype none

module pct_dead_time #(
	parameter int DT_W = pct_pkg::DT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// waveform in
	input wire logic wave,
	input wire logic [DT_W-1:0] dead_time,
	// switch drives
	output logic ls_q,
	output logic hs_q
);

	logic wave_q;
	logic [DT_W-1:0] gap_q;

	// ==========================================================
	// splitter
	// both switches stay off for the gap so the pair never conducts through
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wave_q <= 1'b0;
			gap_q <= '0;
			ls_q <= 1'b0;
			hs_q <= 1'b0;
		end else begin
			wave_q <= wave;
			if (wave != wave_q && dead_time != '0) begin
				gap_q <= dead_time;
				ls_q <= 1'b0;
				hs_q <= 1'b0;
			end else if (gap_q != '0) begin
				gap_q <= gap_q - 1'b1;
			end else begin
				ls_q <= wave;
				hs_q <= ~wave;
			end
		end
	end

	// ==========================================================
	// checks
	a_no_overlap: assert property (@(posedge clk) disable iff (sys_rst)
		!(ls_q && hs_q))
		else $error("low and high side on together");

	a_gap_held: assert property (@(posedge clk) disable iff (sys_rst)
		(wave != wave_q && dead_time != '0) |=> (!ls_q && !hs_q) [*2])
		else $error("dead time gap not held");

endmodule : pct_dead_time

`default_nettype wire

// File: logic/pct_timer.sv
// power control timer core: counter, buffers, faults and output chain
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - keeps counting in sleep while clocked
// - register writes pass a synchroniser first
// - debug halt stops counter unless forced run
// - lockable writes except listed value registers
// - debugger writes ignore the write lock
// - ceiling from period or channel zero
// - zero is all clear, max all set
// - update at ceiling or zero by direction
// - up to six compare/capture channels
// - counter and values 16 or 24 bits
// - each buffer has its own valid flag
// - ceiling hit (up) or zero hit (down) raises irq/event
// - compares set waveform period and width
// - count by prescaled tick or events; capture
// - recoverable fault restarts, halts or blanks
// - channel events shared with recoverable fault
// - recoverable fault filter, blanking, qualification
// - dead time splits four lowest matrix outputs
// - swap exchanges low and high side
// - pattern changes only at update
// - hard fault forces safe output level
// - counter events drive hard fault, unfiltered unless nrf_filt is set
// - direction bit clear up, set down

module pct_timer #(
	parameter int CNT_W = pct_pkg::CNT_W_DEF,
	parameter int CC_NUM = pct_pkg::CC_NUM_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control and register writes
	input wire logic enable,
	input wire logic lock_en,
	input wire pct_pkg::pct_wr_t wr,
	// count sources and events
	input wire logic source_tick,
	input wire logic counter_event_input_0,
	input wire logic counter_event_input_1,
	input wire logic channel_event_input_0,
	input wire logic channel_event_input_1,
	// debug
	input wire logic dbg_halt,
	input wire logic debug_run_control,
	// pins
	output logic [pct_pkg::PIN_NUM-1:0] pins_q,
	// status and events
	output logic [CNT_W-1:0] count_q,
	output logic at_zero_q,
	output logic at_max_q,
	output logic update_q,
	output logic irq_q,
	output logic cap_q,
	output logic sync_busy_q,
	output logic refused_q,
	output logic rf_active_q,
	output logic nrf_active_q,
	output logic perbv_q,
	output logic pattbv_q,
	output logic [CC_NUM-1:0] ccbv_q
);

	localparam int PIN = pct_pkg::PIN_NUM;
	localparam int PAIR = pct_pkg::PAIR_NUM;
	localparam int LAST = pct_pkg::SYNC_STAGES - 1;

	// ==========================================================
	// helpers
	function automatic logic is_zero(input logic [CNT_W-1:0] v);
		return v == '0;
	endfunction : is_zero

	function automatic logic is_max(input logic [CNT_W-1:0] v);
		return &v;
	endfunction : is_max

	function automatic logic lockable(input pct_pkg::pct_wsel_t s);
		return s == pct_pkg::PCT_W_CTRL || s == pct_pkg::PCT_W_FAULT ||
			s == pct_pkg::PCT_W_COUNT;
	endfunction : lockable

	function automatic logic [pct_pkg::FILT_W-1:0] filt_next(
		input logic [pct_pkg::FILT_W-1:0] c, input logic raw);
		if (!raw)
			return '0;
		return (&c) ? c : c + 1'b1;
	endfunction : filt_next

	// ==========================================================
	// state
	pct_pkg::pct_ctrl_t ctrl_q;
	pct_pkg::pct_fault_t fault_q;
	pct_pkg::pct_pattern_value_t pattern_value_q, pattern_buffer_q;
	pct_pkg::pct_wr_t pipe_q [pct_pkg::SYNC_STAGES];
	pct_pkg::pct_wr_t wr_in, app;
	logic [CNT_W-1:0] per_q, period_buffer_q, top, count_d;
	logic [CNT_W-1:0] cc_q [CC_NUM];
	logic [CNT_W-1:0] ccb_q [CC_NUM];
	logic [pct_pkg::FILT_W-1:0] rf_cnt_q, nrf_cnt_q, blank_q;
	logic wr_acc, run, tick, upd, rf_raw, rf_act, rf_prev_q, rf_restart, rf_halt;
	logic nrf_raw, nrf_now, cap_now, busy_d;
	logic [CC_NUM-1:0] wf;
	logic [PAIR-1:0] mx, ls, hs;
	logic [PIN-1:0] pre, pins_d;

	// ==========================================================
	// write intake and synchroniser
	// writes land a fixed number of cycles later, like the cross-domain path
	always_comb begin
		wr_acc = wr.en && !(lock_en && lockable(wr.sel) && !wr.debugger);
		wr_in = wr;
		wr_in.en = wr_acc;
		app = pipe_q[LAST];
		busy_d = wr_acc;
		for (int i = 0; i < LAST; i++)
			busy_d = busy_d | pipe_q[i].en;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < pct_pkg::SYNC_STAGES; i++)
				pipe_q[i] <= '0;
			sync_busy_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			pipe_q[0] <= wr_in;
			for (int i = 1; i < pct_pkg::SYNC_STAGES; i++)
				pipe_q[i] <= pipe_q[i-1];
			sync_busy_q <= busy_d;
			refused_q <= wr.en && !wr_acc;
		end
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q <= '0;
			fault_q <= '0;
		end else if (app.en) begin
			if (app.sel == pct_pkg::PCT_W_CTRL)
				ctrl_q <= app.data[$bits(pct_pkg::pct_ctrl_t)-1:0];
			if (app.sel == pct_pkg::PCT_W_FAULT)
				fault_q <= app.data[$bits(pct_pkg::pct_fault_t)-1:0];
		end
	end

	// ==========================================================
	// counter
	// no sleep gating here: while clk runs, only enable, debug halt and fault halt stop the counter
	always_comb begin
		run = enable && !(dbg_halt && !debug_run_control) && !rf_halt;
		tick = ctrl_q.count_events ? counter_event_input_0 : source_tick;
		top = ctrl_q.top_cc0 ? cc_q[0] : per_q;
		upd = run && tick && (ctrl_q.dir ? is_zero(count_q) : count_q == top);
		count_d = count_q;
		if (run && tick) begin
			if (upd)
				count_d = ctrl_q.dir ? top : '0;
			else if (ctrl_q.dir)
				count_d = count_q - 1'b1;
			else
				count_d = count_q + 1'b1;
		end
		if (rf_restart)
			count_d = ctrl_q.dir ? top : '0;
		if (app.en && app.sel == pct_pkg::PCT_W_COUNT)
			count_d = app.data[CNT_W-1:0];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count_q <= '0;
			at_zero_q <= 1'b1;
			at_max_q <= 1'b0;
			update_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			count_q <= count_d;
			at_zero_q <= is_zero(count_d);
			at_max_q <= is_max(count_d);
			update_q <= upd;
			irq_q <= upd || (nrf_now && !nrf_active_q);
		end
	end

	// ==========================================================
	// buffered values; a write in the update cycle keeps its valid flag
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			per_q <= '1;
			period_buffer_q <= '0;
			perbv_q <= 1'b0;
			pattern_value_q <= '0;
			pattern_buffer_q <= '0;
			pattbv_q <= 1'b0;
		end else begin
			if (upd && perbv_q) begin
				per_q <= period_buffer_q;
				perbv_q <= 1'b0;
			end
			if (upd && pattbv_q) begin
				pattern_value_q <= pattern_buffer_q;
				pattbv_q <= 1'b0;
			end
			if (app.en && app.sel == pct_pkg::PCT_W_PERIOD_BUFFER) begin
				period_buffer_q <= app.data[CNT_W-1:0];
				perbv_q <= 1'b1;
			end
			if (app.en && app.sel == pct_pkg::PCT_W_PATTERN_BUFFER) begin
				pattern_buffer_q <= app.data[$bits(pct_pkg::pct_pattern_value_t)-1:0];
				pattbv_q <= 1'b1;
			end
		end
	end

	assign cap_now = ctrl_q.cap_en && !fault_q.rf_en && channel_event_input_0;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < CC_NUM; i++) begin
				cc_q[i] <= '0;
				ccb_q[i] <= '0;
			end
			ccbv_q <= '0;
			cap_q <= 1'b0;
		end else begin
			for (int i = 0; i < CC_NUM; i++) begin
				if (upd && ccbv_q[i]) begin
					cc_q[i] <= ccb_q[i];
					ccbv_q[i] <= 1'b0;
				end
				if (app.en && app.sel == pct_pkg::PCT_W_CCB && int'(app.idx) == i) begin
					ccb_q[i] <= app.data[CNT_W-1:0];
					ccbv_q[i] <= 1'b1;
				end
			end
			if (cap_now)
				cc_q[CC_NUM-1] <= count_q;
			cap_q <= cap_now;
		end
	end

	// ==========================================================
	// recoverable fault: raw channel events, no resync, as the fault path needs
	always_comb begin
		rf_raw = channel_event_input_0 || channel_event_input_1;
		rf_act = fault_q.rf_en && rf_raw && rf_cnt_q >= fault_q.filt &&
			blank_q == '0 && (!fault_q.qual || count_q < cc_q[0]);
		rf_restart = rf_act && !rf_prev_q && fault_q.action == pct_pkg::PCT_RF_RESTART;
		rf_halt = rf_act && fault_q.action == pct_pkg::PCT_RF_HALT;
		nrf_raw = counter_event_input_0 || counter_event_input_1;
		nrf_now = fault_q.nrf_en && nrf_raw &&
			(!fault_q.nrf_filt || nrf_cnt_q >= fault_q.filt);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rf_cnt_q <= '0;
			nrf_cnt_q <= '0;
			blank_q <= '0;
			rf_prev_q <= 1'b0;
			rf_active_q <= 1'b0;
			nrf_active_q <= 1'b0;
		end else begin
			rf_cnt_q <= filt_next(rf_cnt_q, rf_raw);
			nrf_cnt_q <= filt_next(nrf_cnt_q, nrf_raw);
			if (upd)
				blank_q <= fault_q.blank;
			else if (blank_q != '0)
				blank_q <= blank_q - 1'b1;
			rf_prev_q <= rf_act;
			rf_active_q <= rf_act;
			nrf_active_q <= nrf_now;
		end
	end

	// ==========================================================
	// waveform and output chain
	always_comb begin
		for (int i = 0; i < CC_NUM; i++) begin
			wf[i] = count_q < cc_q[i];
			if (rf_act && fault_q.action == pct_pkg::PCT_RF_BLANK)
				wf[i] = 1'b0;
		end
		for (int k = 0; k < PAIR; k++) begin
			case (ctrl_q.output_matrix)
				pct_pkg::OUTPUT_MATRIX_PAIRS: mx[k] = wf[k % 2];
				pct_pkg::OUTPUT_MATRIX_CH0: mx[k] = wf[0];
				default: mx[k] = wf[k % CC_NUM];
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < PAIR; g++) begin : g_dti
			pct_dead_time #(
				.DT_W(pct_pkg::DT_W)
			) u_dti (
				.clk(clk),
				.sys_rst(sys_rst),
				.wave(mx[g]),
				.dead_time(ctrl_q.dead_time),
				.ls_q(ls[g]),
				.hs_q(hs[g])
			);
		end
	endgenerate

	always_comb begin
		for (int k = 0; k < PAIR; k++) begin
			pre[2*k] = ctrl_q.swap[k] ? hs[k] : ls[k];
			pre[2*k+1] = ctrl_q.swap[k] ? ls[k] : hs[k];
		end
		for (int p = 0; p < PIN; p++)
			if (pattern_value_q.en[p])
				pre[p] = pattern_value_q.val[p];
		pins_d = nrf_now ? fault_q.safe_level : pre;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			pins_q <= '0;
		else
			pins_q <= pins_d;
	end

	// ==========================================================
	// checks
	a_lock_refuse: assert property (@(posedge clk) disable iff (sys_rst)
		(wr.en && lock_en && !wr.debugger && (wr.sel == pct_pkg::PCT_W_CTRL ||
		wr.sel == pct_pkg::PCT_W_COUNT || wr.sel == pct_pkg::PCT_W_FAULT))
		|=> refused_q ##1 !pipe_q[LAST].en)
		else $error("locked write not refused");

	a_debug_bypass: assert property (@(posedge clk) disable iff (sys_rst)
		(wr.en && wr.debugger) |=> !refused_q ##1 pipe_q[LAST].en)
		else $error("debugger write was refused");

	a_sync_delay: assert property (@(posedge clk) disable iff (sys_rst)
		(wr.en && !lock_en && wr.sel == pct_pkg::PCT_W_COUNT)
		|=> sync_busy_q ##2 count_q == $past(wr.data[CNT_W-1:0], 3))
		else $error("count write not applied after sync");

	a_debug_halt: assert property (@(posedge clk) disable iff (sys_rst)
		(dbg_halt && !debug_run_control && !app.en && !rf_restart) |=> $stable(count_q))
		else $error("counter moved during debug halt");

	a_up_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		(upd && !ctrl_q.dir && !app.en && !rf_restart) |=> count_q == '0 && update_q && irq_q)
		else $error("up count did not wrap at ceiling");

	a_down_reload: assert property (@(posedge clk) disable iff (sys_rst)
		(upd && ctrl_q.dir && !app.en && !rf_restart) |=> count_q == $past(top))
		else $error("down count did not reload ceiling");

	a_zero_flag: assert property (@(posedge clk) disable iff (sys_rst)
		at_zero_q == (count_q == '0) && at_max_q == (&count_q))
		else $error("zero or max flag wrong");

	a_pattern_load: assert property (@(posedge clk) disable iff (sys_rst)
		(!upd && !(app.en && app.sel == pct_pkg::PCT_W_PATTERN_BUFFER)) |=> !$changed(pattern_value_q))
		else $error("pattern changed outside update");

	a_nrf_force: assert property (@(posedge clk) disable iff (sys_rst)
		nrf_now |=> pins_q == $past(fault_q.safe_level) && nrf_active_q)
		else $error("hard fault did not force safe level");

	a_buf_valid: assert property (@(posedge clk) disable iff (sys_rst)
		(app.en && app.sel == pct_pkg::PCT_W_PERIOD_BUFFER) |=> perbv_q && period_buffer_q == $past(app.data[CNT_W-1:0]))
		else $error("period buffer valid not set");

endmodule : pct_timer

`default_nettype wire

// File: dv/pct_evsys_model.sv
// event system stand-in that raises the timer's event lines on request
`timescale 1ns/1ps
`default_nettype none

module pct_evsys_model (
	// clock
	input wire logic clk,
	// requested levels: ce0, ce1, he0, he1
	input wire logic [3:0] req,
	// event lines
	output logic channel_event_input_0,
	output logic channel_event_input_1,
	output logic counter_event_input_0,
	output logic counter_event_input_1
);
	// ==========================================================
	// event levels
	// events come out one edge late, as a routed path would
	always @(posedge clk) begin
		{counter_event_input_1, counter_event_input_0} <= req[3:2];
		{channel_event_input_1, channel_event_input_0} <= req[1:0];
	end
endmodule : pct_evsys_model
`default_nettype wire

// File: dv/tb.sv
// self-checking bench of the power control timer core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) bad(nm, e, g); end

module tb;
	// ==========================================================
	// stimulus and wiring
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic enable = 1'b0;
	logic lock_en = 1'b0;
	logic source_tick = 1'b0;
	logic rnd_tick = 1'b0;
	logic dbg_halt = 1'b0;
	logic debug_run_control = 1'b0;
	logic [3:0] ev_req = 4'h0;
	pct_pkg::pct_wr_t wr = '0;
	pct_pkg::pct_ctrl_t cr;
	pct_pkg::pct_fault_t fl;
	wire ce0, ce1, he0, he1;
	logic [7:0] pins_q;
	logic [23:0] count_q;
	logic at_zero_q, at_max_q, update_q, irq_q, cap_q, sync_busy_q, refused_q;
	logic rf_active_q, nrf_active_q, perbv_q, pattbv_q;
	logic [5:0] ccbv_q;
	int seed = 89;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	logic [23:0] v, c;
	logic [7:0] val;
	int p, q;

	initial begin
		forever #25 clk = ~clk;
	end

	pct_evsys_model evs (.clk(clk), .req(ev_req), .channel_event_input_0(ce0),
		.channel_event_input_1(ce1), .counter_event_input_0(he0),
		.counter_event_input_1(he1));

	pct_timer #(.CNT_W(24), .CC_NUM(6)) dut (.clk(clk), .sys_rst(sys_rst), .enable(enable),
		.lock_en(lock_en), .wr(wr), .source_tick(source_tick),
		.counter_event_input_0(he0), .counter_event_input_1(he1),
		.channel_event_input_0(ce0), .channel_event_input_1(ce1), .dbg_halt(dbg_halt),
		.debug_run_control(debug_run_control), .pins_q(pins_q), .count_q(count_q),
		.at_zero_q(at_zero_q), .at_max_q(at_max_q), .update_q(update_q), .irq_q(irq_q),
		.cap_q(cap_q), .sync_busy_q(sync_busy_q), .refused_q(refused_q),
		.rf_active_q(rf_active_q), .nrf_active_q(nrf_active_q), .perbv_q(perbv_q),
		.pattbv_q(pattbv_q), .ccbv_q(ccbv_q));

	// ==========================================================
	// helpers
	task automatic bad(input string nm, input logic [23:0] e, input logic [23:0] g);
		$display("BAD %s expected %h seen %h", nm, e, g);
		n_fail++;
	endtask : bad

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	// ticks go random while rnd_tick is set, in the period measurements and the pattern and hard fault tests
	task automatic step(input int n = 1);
		repeat (n) begin
			@(posedge clk);
			#2;
			if (rnd_tick) source_tick = 1'($random(seed));
		end
	endtask : step

	task automatic wr_reg(input pct_pkg::pct_wsel_t s, input logic [2:0] i,
		input logic [23:0] d, input logic dbg);
		wr.en = 1'b1;
		wr.sel = s;
		wr.idx = i;
		wr.data = d;
		wr.debugger = dbg;
		step();
		wr.en = 1'b0;
	endtask : wr_reg

	task automatic wait_upd();
		for (int k = 0; k < 400 && update_q !== 1'b1; k++) step();
		`CHK("update", 1'b1, update_q)
		`CHK("irq", 1'b1, irq_q)
	endtask : wait_upd

	// ticks sampled between two updates give the cycle length
	task automatic measure(input int e);
		int n;
		logic t;
		n = 0;
		wait_upd();
		do begin
			t = source_tick;
			step();
			n += int'(t);
		end while (update_q !== 1'b1 && n < 400);
		`CHK("period", e, n)
	endtask : measure

	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			end_sim();
		end
	end

	// ==========================================================
	// scenarios
	initial begin
		step(2);
		sys_rst = 1'b0;
		`CHK("count", 24'h0, count_q)
		`CHK("zero", 1'b1, at_zero_q)
		`CHK("max", 1'b0, at_max_q)
		`CHK("pins", 8'h0, pins_q)
		$display("test reset done");

		v = 24'($random(seed)) | 24'h1;
		wr_reg(pct_pkg::PCT_W_COUNT, 3'h0, v, 1'b0);
		`CHK("busy", 1'b1, sync_busy_q)
		step();
		`CHK("count", 24'h0, count_q)
		step();
		`CHK("count", v, count_q)
		lock_en = 1'b1;
		wr_reg(pct_pkg::PCT_W_COUNT, 3'h0, ~v, 1'b0);
		`CHK("refused", 1'b1, refused_q)
		step(3);
		`CHK("count", v, count_q)
		wr_reg(pct_pkg::PCT_W_COUNT, 3'h0, 24'hffffff, 1'b1);
		step(4);
		`CHK("count", 24'hffffff, count_q)
		`CHK("max", 1'b1, at_max_q)
		p = 3 + {$random(seed)} % 28;
		wr_reg(pct_pkg::PCT_W_PERIOD_BUFFER, 3'h0, 24'(p), 1'b0);
		step(3);
		`CHK("perbv", 1'b1, perbv_q)
		lock_en = 1'b0;
		$display("test sync and lock done");

		enable = 1'b1;
		rnd_tick = 1'b1;
		wait_upd();
		`CHK("perbv", 1'b0, perbv_q)
		measure(p + 1);
		$display("test period done");

		rnd_tick = 1'b0;
		source_tick = 1'b1;
		dbg_halt = 1'b1;
		step();
		c = count_q;
		step(3);
		`CHK("halted", c, count_q)
		debug_run_control = 1'b1;
		step(2);
		`CHK("forced run", 1'b1, count_q !== c)
		dbg_halt = 1'b0;
		debug_run_control = 1'b0;
		source_tick = 1'b0;
		$display("test debug done");

		cr = '0;
		cr.dir = 1'b1;
		wr_reg(pct_pkg::PCT_W_CTRL, 3'h0, 24'(cr), 1'b0);
		rnd_tick = 1'b1;
		measure(p + 1);
		rnd_tick = 1'b0;
		source_tick = 1'b1;
		step();
		c = count_q;
		step();
		`CHK("down", c - 24'h1, count_q)
		source_tick = 1'b0;
		$display("test down done");

		q = 3 + {$random(seed)} % 28;
		wr_reg(pct_pkg::PCT_W_CCB, 3'h0, 24'(q), 1'b0);
		step(3);
		`CHK("ccbv0", 1'b1, ccbv_q[0])
		source_tick = 1'b1;
		wait_upd();
		enable = 1'b0;
		cr.dir = 1'b0;
		cr.top_cc0 = 1'b1;
		cr.dead_time = 8'h3;
		wr_reg(pct_pkg::PCT_W_CTRL, 3'h0, 24'(cr), 1'b0);
		step();
		wr_reg(pct_pkg::PCT_W_COUNT, 3'h0, 24'h0, 1'b0);
		step(3);
		enable = 1'b1;
		rnd_tick = 1'b1;
		measure(q + 1);
		$display("test channel zero top done");

		val = 8'($random(seed));
		enable = 1'b0;
		wr_reg(pct_pkg::PCT_W_PATTERN_BUFFER, 3'h0, 24'({8'hff, val}), 1'b0);
		step(3);
		`CHK("pattbv", 1'b1, pattbv_q)
		enable = 1'b1;
		wait_upd();
		step(3);
		`CHK("pattern", val, pins_q)
		`CHK("pattbv", 1'b0, pattbv_q)
		$display("test pattern done");

		fl = '0;
		fl.nrf_en = 1'b1;
		fl.safe_level = ~val;
		wr_reg(pct_pkg::PCT_W_FAULT, 3'h0, 24'(fl), 1'b0);
		step(3);
		ev_req = 4'h8;
		step(3);
		`CHK("safe pins", ~val, pins_q)
		`CHK("hard fault", 1'b1, nrf_active_q)
		ev_req = 4'h0;
		wr_reg(pct_pkg::PCT_W_FAULT, 3'h0, 24'h0, 1'b0);
		$display("test hard fault done");

		rnd_tick = 1'b0;
		source_tick = 1'b0;
		cr.cap_en = 1'b1;
		cr.count_events = 1'b1;
		wr_reg(pct_pkg::PCT_W_CTRL, 3'h0, 24'(cr), 1'b0);
		step(4);
		c = count_q;
		ev_req = 4'h4;
		step();
		ev_req = 4'h0;
		step(3);
		`CHK("event count", 1'b1, count_q !== c)
		ev_req = 4'h1;
		step();
		ev_req = 4'h0;
		for (int k = 0; k < 6 && cap_q !== 1'b1; k++) step();
		`CHK("capture", 1'b1, cap_q)
		$display("test events done");

		fl = '0;
		fl.rf_en = 1'b1;
		fl.action = pct_pkg::PCT_RF_HALT;
		wr_reg(pct_pkg::PCT_W_FAULT, 3'h0, 24'(fl), 1'b0);
		step(3);
		ev_req = 4'h2;
		step(3);
		`CHK("soft fault", 1'b1, rf_active_q)
		ev_req = 4'h0;
		$display("test soft fault done");
		end_sim();
	end
endmodule : tb
`default_nettype wire
